// *** verilog/srs_reset_supervisor.sv ***
`timescale 1ns/100ps
// Function
// - system reset clears processor, peripherals and their registers, except status and watchdog enable.
// - readable status register records reset causes and monitor interrupts.
// - power-on reset empties the status register.
// - power-on trip gives reset pulse at least 150 ns, longer while ramping.
// - after boot the power-on monitor is off; precise monitor takes over.
// - precise monitor trip gives the same reset as power-on.
// - digital precise half cannot be disabled; analog regulator off disables analog half.
// - precise monitor off in sleep and hibernate, except during sleep buzz.
// - low-voltage monitors take programmable trip setting in 250 mV steps.
// - high-voltage monitor uses one fixed 5.75 V trip level.
// - each low-voltage monitor may reset instead of interrupting.
// - supply monitors stay disabled until power-on reset finishes.
// - sleep buzz interrupt first wakes device, then presents the interrupt.
// - external pin low holds reset, same response as power-on, has pull-up.
// - external pin resets in sleep and hibernate too.
// - software reset bit, from processor or DMA, resets like power-on.
// - separate bit blocks the software reset bit.
// - enabled watchdog resets when not restarted within timeout.
// - power-on reset leaves watchdog disabled; software sets enable bit.
// - watchdog enable is sticky; only power-on reset clears it.
module srs_reset_supervisor
	import srs_pkg::*;
#(
	parameter int RELEASE_CYC = 2
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic power_on_trip_i,
	input wire logic supply_ramping_i,
	input wire logic precise_dig_trip_i,
	input wire logic precise_ana_trip_i,
	input wire logic external_reset_pin_n_i,
	input wire logic [3:0] vddd_level_i,
	input wire logic [3:0] vdda_level_i,
	input wire logic vdda_over_i,
	input wire logic sleep_i,
	input wire logic hibernate_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	output logic sys_reset_n_o,
	output logic power_on_enable_o,
	output logic precise_dig_enable_o,
	output logic precise_ana_enable_o,
	output logic monitor_enable_o,
	output logic external_reset_pullup_o,
	output logic wake_req_o,
	output logic supply_irq_o
);
	// ************************************************
	// input synchronisers
	// ************************************************
	logic [10:0] sync1;
	logic [10:0] sync2;
	logic [3:0] dl1;
	logic [3:0] dl2;
	logic [3:0] al1;
	logic [3:0] al2;
	wire [10:0] raw_in = {power_on_trip_i, supply_ramping_i, precise_dig_trip_i, precise_ana_trip_i,
		external_reset_pin_n_i, vdda_over_i, sleep_i, hibernate_i, 3'h0};

	// two flops on every pin-side input
	// pin reset value is high so no false pin reset follows nrst_i
	// level codes reset to full scale so no false low-voltage event
	// every source is a level, so two cycles of latency cost nothing
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sync1 <= 11'h040;
			sync2 <= 11'h040;
			dl1 <= 4'hf;
			dl2 <= 4'hf;
			al1 <= 4'hf;
			al2 <= 4'hf;
		end else begin
			sync1 <= raw_in;
			sync2 <= sync1;
			dl1 <= vddd_level_i;
			dl2 <= dl1;
			al1 <= vdda_level_i;
			al2 <= al1;
		end
	end

	// only the second flop of each chain is read below
	// bits 2..0 of the chains are spare and stay zero
	wire pon_s = sync2[10];
	wire ramp_s = sync2[9];
	wire prec_d_s = sync2[8];
	wire prec_a_s = sync2[7];
	wire pin_n_s = sync2[6];
	wire ahv_s = sync2[5];
	wire sleep_s = sync2[4];
	wire hib_s = sync2[3];

	// ************************************************
	// registers
	// ************************************************
	logic [ST_W-1:0] status;
	logic sw_block;
	logic sw_go;
	logic wdt_en;
	logic [31:0] wdt_timeout;
	logic [31:0] wdt_cnt;
	logic [LV_TRIP_W-1:0] dtrip;
	logic [LV_TRIP_W-1:0] atrip;
	logic d_rst_mode;
	logic a_rst_mode;
	logic areg_off;
	logic [CNT_W-1:0] buzz_period;
	logic [CNT_W-1:0] buzz_cnt;
	logic [2:0] buzz_on;
	logic booted;
	logic [7:0] por_cnt;
	logic [7:0] rel_cnt;
	logic irq_pending;

	// write decode
	// unmapped addresses match nothing, so writes there are dropped
	// control register writes are also ignored while the system is held in reset; status clears and watchdog enable writes still act
	wire wr_status = wr_i && (addr_i == REG_STATUS);
	wire wr_swrst = wr_i && (addr_i == REG_SWRST);
	wire wr_wdt = wr_i && (addr_i == REG_WDT_CTRL);
	wire wr_kick = wr_i && (addr_i == REG_WDT_KICK);
	wire wr_lv = wr_i && (addr_i == REG_LV_CFG);
	wire wr_buzz = wr_i && (addr_i == REG_BUZZ);
	wire wr_pwr = wr_i && (addr_i == REG_PWR);

	// ************************************************
	// power-on pulse and boot hand-off
	// ************************************************
	// power-on event: full reset, status and watchdog enable cleared
	// a trip after boot is ignored here; the precise monitor owns supervision then
	wire por_event = !booted ? pon_s : 1'b0;
	// minimum width counted in clocks, stretched while any supply still ramps
	wire por_pulse = (por_cnt != 8'h00) || ramp_s && !booted;
	wire por_active = por_event || por_pulse;

	// buzz window in sleep
	// the precise monitor is only trusted while awake or inside a buzz window
	wire buzzing = sleep_s && (buzz_on != 3'h0);
	wire prec_window = booted && (!(sleep_s || hib_s) || buzzing);
	// analog half drops out with the analog regulator; digital half always counts
	wire prec_trip = prec_window && (prec_d_s || (prec_a_s && !areg_off));
	// supply monitors stay dark until boot, and in hibernate
	wire mon_window = booted && !hib_s && (!sleep_s || buzzing);

	// low-voltage compare on trip codes, high-voltage is fixed comparator
	// a level code at or below the trip code counts as low
	wire dlv = mon_window && (dl2 <= dtrip);
	wire alv = mon_window && (al2 <= atrip);
	wire ahv = mon_window && ahv_s;
	wire lv_reset = (dlv && d_rst_mode) || (alv && a_rst_mode);

	// pin is already synchronised; low means asserted
	wire pin_act = !pin_n_s;
	// block bit masks the go bit without clearing it
	wire soft_act = sw_go && !sw_block;
	// counter stops at the limit, so the source holds until reset clears it
	wire wdog_act = wdt_en && (wdt_cnt >= wdt_timeout);

	// any source holds reset; fresh sources restart release count
	wire any_src = por_active || prec_trip || pin_act || soft_act || wdog_act || lv_reset;

	// power-on pulse counter and boot flag
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			por_cnt <= 8'(POR_MIN_CYC);
			booted <= 1'b0;
		end else if (pon_s && !booted) begin
			// a trip during the pulse restarts the minimum width
			por_cnt <= 8'(POR_MIN_CYC);
		end else begin
			if (por_cnt != 8'h00)
				por_cnt <= por_cnt - 8'h01;
			// boot ends once the pulse has run out and the monitor is quiet
			if (!por_pulse && !pon_s)
				booted <= 1'b1;
		end
	end

	// synchronous release after all sources drop
	// output is a flop so downstream logic never sees a glitch
	// a source that reappears during the count restarts it
	// the release count gives late sources time to show up
	// before the system is let go
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rel_cnt <= 8'h00;
			sys_reset_n_o <= 1'b0;
		end else if (any_src) begin
			rel_cnt <= 8'(RELEASE_CYC);
			sys_reset_n_o <= 1'b0;
		end else if (rel_cnt != 8'h00) begin
			rel_cnt <= rel_cnt - 8'h01;
		end else begin
			sys_reset_n_o <= 1'b1;
		end
	end

	wire in_reset = !sys_reset_n_o;

	// ************************************************
	// software controls
	// ************************************************
	// system reset returns registers to defaults; power-on alone touches wdt_en
	// the go bit clears itself through this reset, so one write gives one reset
	// the watchdog timeout can only be loaded while the watchdog is off
	// so a runaway program cannot stretch it once armed
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sw_block <= 1'b0;
			sw_go <= 1'b0;
			dtrip <= LV_TRIP_RST;
			atrip <= LV_TRIP_RST;
			d_rst_mode <= 1'b0;
			a_rst_mode <= 1'b0;
			areg_off <= 1'b0;
			buzz_period <= BUZZ_RST;
			wdt_timeout <= WDT_RST;
		end else if (in_reset) begin
			sw_block <= 1'b0;
			sw_go <= 1'b0;
			dtrip <= LV_TRIP_RST;
			atrip <= LV_TRIP_RST;
			d_rst_mode <= 1'b0;
			a_rst_mode <= 1'b0;
			areg_off <= 1'b0;
			buzz_period <= BUZZ_RST;
			wdt_timeout <= WDT_RST;
		end else begin
			if (wr_swrst) begin
				sw_block <= wdata_i[SW_BLOCK];
				sw_go <= wdata_i[SW_GO];
			end
			if (wr_lv) begin
				dtrip <= wdata_i[LV_DTRIP +: LV_TRIP_W];
				atrip <= wdata_i[LV_ATRIP +: LV_TRIP_W];
				d_rst_mode <= wdata_i[LV_DRST];
				a_rst_mode <= wdata_i[LV_ARST];
			end
			if (wr_pwr)
				areg_off <= wdata_i[PWR_AREG_OFF];
			if (wr_buzz)
				buzz_period <= wdata_i[CNT_W-1:0];
			if (wr_wdt && !wdt_en)
				wdt_timeout <= wdata_i;
		end
	end

	// watchdog enable and counter
	// enable is sticky: writes can only set it
	// counter is held at zero in reset and on every kick
	// counting stops at the limit so the reset source stays asserted
	// until the system reset zeroes it
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wdt_en <= 1'b0;
			wdt_cnt <= 32'h0;
		end else if (por_active) begin
			wdt_en <= 1'b0;
			wdt_cnt <= 32'h0;
		end else begin
			if (wr_wdt && wdata_i[WDT_EN])
				wdt_en <= 1'b1;
			if (in_reset || wr_kick || !wdt_en)
				wdt_cnt <= 32'h0;
			else if (wdt_cnt < wdt_timeout)
				wdt_cnt <= wdt_cnt + 32'h1;
		end
	end

	// buzz timer runs only in sleep
	// period comes from software; each expiry opens a short window
	// in which the monitors are powered and sampled
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			buzz_cnt <= 16'h0;
			buzz_on <= 3'h0;
		end else if (!sleep_s) begin
			buzz_cnt <= 16'h0;
			buzz_on <= 3'h0;
		end else if (buzz_cnt >= buzz_period) begin
			buzz_cnt <= 16'h0;
			buzz_on <= 3'(BUZZ_ON_CYC);
		end else begin
			buzz_cnt <= buzz_cnt + 16'h1;
			if (buzz_on != 3'h0)
				buzz_on <= buzz_on - 3'h1;
		end
	end

	// ************************************************
	// status, wake and interrupt
	// ************************************************
	// low-voltage monitors in reset mode report as reset, not as interrupt
	// power-on itself leaves no cause behind: it empties the register
	// an event standing in the cycle of a clear survives it
	wire [ST_W-1:0] events = {ahv, alv && !a_rst_mode, dlv && !d_rst_mode, wdog_act, soft_act, pin_act, prec_trip};
	wire irq_src = ahv || (alv && !a_rst_mode) || (dlv && !d_rst_mode);

	// sticky causes; set wins over software clear
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			status <= '0;
		end else if (por_active) begin
			status <= '0;
		end else if (wr_status) begin
			status <= (status & ~wdata_i[ST_W-1:0]) | events;
		end else begin
			status <= status | events;
		end
	end

	// interrupt held as wake request in sleep, presented once awake
	// a status write acknowledges it unless the source still stands
	// the pending flag survives the sleep to wake transition
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			irq_pending <= 1'b0;
		end else if (in_reset) begin
			irq_pending <= 1'b0;
		end else if (irq_src) begin
			irq_pending <= 1'b1;
		end else if (wr_status) begin
			irq_pending <= 1'b0;
		end
	end

	assign wake_req_o = irq_pending && sleep_s;
	assign supply_irq_o = irq_pending && !sleep_s;

	// ************************************************
	// monitor enables and read port
	// ************************************************
	// power-on monitor runs only until boot completes
	assign power_on_enable_o = !booted;
	// no software bit reaches the digital enable
	assign precise_dig_enable_o = prec_window;
	assign precise_ana_enable_o = prec_window && !areg_off;
	assign monitor_enable_o = mon_window;
	assign external_reset_pullup_o = 1'b1;

	wire [31:0] rd_mux =
		(addr_i == REG_STATUS) ? {25'h0, status} :
		(addr_i == REG_SWRST) ? {30'h0, sw_block, sw_go} :
		(addr_i == REG_WDT_CTRL) ? {31'h0, wdt_en} :
		(addr_i == REG_WDT_KICK) ? wdt_cnt :
		(addr_i == REG_LV_CFG) ? {22'h0, a_rst_mode, d_rst_mode, atrip, dtrip} :
		(addr_i == REG_BUZZ) ? {16'h0, buzz_period} :
		(addr_i == REG_PWR) ? {31'h0, areg_off} : 32'h0;

	// read data one cycle after strobe
	// zero outside that cycle, so a stale read never lingers
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			rdata_o <= 32'h0;
		else
			rdata_o <= rd_i ? rd_mux : 32'h0;
	end
endmodule

// *** verilog/srs_pkg.sv ***
package srs_pkg;
	// ************************************************
	// register map (word offsets on the plain port)
	// ************************************************
	localparam int ADDR_W = 4;
	localparam logic [3:0] REG_STATUS = 4'h0;
	localparam logic [3:0] REG_SWRST = 4'h1;
	localparam logic [3:0] REG_WDT_CTRL = 4'h2;
	localparam logic [3:0] REG_WDT_KICK = 4'h3;
	localparam logic [3:0] REG_LV_CFG = 4'h4;
	localparam logic [3:0] REG_BUZZ = 4'h5;
	localparam logic [3:0] REG_PWR = 4'h6;

	// status bit positions
	localparam int ST_PRECISE = 0;
	localparam int ST_PIN = 1;
	localparam int ST_SOFT = 2;
	localparam int ST_WDOG = 3;
	localparam int ST_DLOW = 4;
	localparam int ST_ALOW = 5;
	localparam int ST_AHIGH = 6;
	localparam int ST_W = 7;

	// control bit positions
	localparam int SW_GO = 0;
	localparam int SW_BLOCK = 1;
	localparam int WDT_EN = 0;
	localparam int LV_TRIP_W = 4;
	localparam int LV_DTRIP = 0;
	localparam int LV_ATRIP = 4;
	localparam int LV_DRST = 8;
	localparam int LV_ARST = 9;
	localparam int PWR_AREG_OFF = 0;

	// trip code: 0 means 1.70 V, step 250 mV, 15 means 5.45 V
	localparam logic [3:0] LV_TRIP_RST = 4'h0;
	localparam logic [15:0] BUZZ_RST = 16'h03e8;
	localparam logic [31:0] WDT_RST = 32'h0000ffff;

	// timing
	localparam int CLK_MHZ = 50;
	localparam int POR_MIN_NS = 150;
	localparam int POR_MIN_CYC = (POR_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int BUZZ_ON_CYC = 4;
	localparam int CNT_W = 16;
endpackage

// *** verification/srs_supply_model.sv ***
`timescale 1ns/100ps
// ****
// supply monitors and reset pin driver
// ****
module srs_supply_model (
	input wire logic clk_i,
	output logic power_on_trip_i,
	output logic supply_ramping_i,
	output logic precise_dig_trip_i,
	output logic precise_ana_trip_i,
	output logic external_reset_pin_n_i,
	output logic [3:0] vddd_level_i,
	output logic [3:0] vdda_level_i,
	output logic vdda_over_i
);
	int quiet = 500;
	// supplies still ramping at power-up
	initial begin
		{power_on_trip_i, precise_dig_trip_i, precise_ana_trip_i, vdda_over_i} = 4'h0;
		{vddd_level_i, vdda_level_i} = 8'hff;
		external_reset_pin_n_i = 1'b1;
		supply_ramping_i = 1'b1;
		repeat (30) @(posedge clk_i);
		supply_ramping_i <= 1'b0;
	end
	// cycles since the pin was released
	always @(posedge clk_i) quiet <= external_reset_pin_n_i ? quiet + 1 : 0;
	// pull-up brings the pin back high on release
	task automatic pin_low(input int n);
		while (quiet < 500) @(posedge clk_i);
		external_reset_pin_n_i <= 1'b0;
		repeat (n) @(posedge clk_i);
		external_reset_pin_n_i <= 1'b1;
	endtask
	// precise monitor trip pulse
	task automatic precise_lv_reset_pulse(input int n);
		precise_dig_trip_i <= 1'b1;
		repeat (n) @(posedge clk_i);
		precise_dig_trip_i <= 1'b0;
	endtask
	// supply level codes and overvoltage comparator
	task automatic lv(input logic [3:0] d, input logic [3:0] a, input logic o);
		vddd_level_i <= d;
		vdda_level_i <= a;
		vdda_over_i <= o;
	endtask
endmodule

// *** verification/srs_reset_supervisor_props.sv ***
`timescale 1ns/100ps
// ****
// reset supervisor port checks
// ****
module srs_reset_supervisor_props #(
	parameter int RELEASE_CYC = 2
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic supply_ramping_i,
	input wire logic precise_dig_trip_i,
	input wire logic external_reset_pin_n_i,
	input wire logic vdda_over_i,
	input wire logic sleep_i,
	input wire logic hibernate_i,
	input wire logic sys_reset_n_o,
	input wire logic power_on_enable_o,
	input wire logic precise_dig_enable_o,
	input wire logic precise_ana_enable_o,
	input wire logic monitor_enable_o,
	input wire logic external_reset_pullup_o,
	input wire logic supply_irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	// source to reset relations
	property p_pin; (!external_reset_pin_n_i) [*6] |-> !sys_reset_n_o && external_reset_pullup_o; endproperty
	a_pin: assert property (p_pin) else $error("pin low without reset");
	property p_rel; $rose(sys_reset_n_o) |-> $past(external_reset_pin_n_i, 2) && !$past(precise_dig_trip_i, 2); endproperty
	a_rel: assert property (p_rel) else $error("release with source active");
	property p_precise_lv_reset; precise_dig_trip_i && precise_dig_enable_o |-> ##[1:4] !sys_reset_n_o; endproperty
	a_precise_lv_reset: assert property (p_precise_lv_reset) else $error("precise trip without reset");
	property p_ramp; (supply_ramping_i && power_on_enable_o) [*4] |-> !sys_reset_n_o; endproperty
	a_ramp: assert property (p_ramp) else $error("boot pulse not stretched");
	// monitor power enables
	property p_boot; sys_reset_n_o && $past(sys_reset_n_o) |-> !power_on_enable_o; endproperty
	a_boot: assert property (p_boot) else $error("power-on monitor on after boot");
	property p_mon; power_on_enable_o |-> !monitor_enable_o; endproperty
	a_mon: assert property (p_mon) else $error("monitors on before boot");
	// mode pins pass two synchroniser flops before they act
	property p_dig; !$past(sleep_i, 2) && !$past(hibernate_i, 2) && !power_on_enable_o |-> precise_dig_enable_o; endproperty
	a_dig: assert property (p_dig) else $error("digital precise half off");
	property p_hib; $past(hibernate_i, 2) |-> !precise_dig_enable_o && !precise_ana_enable_o; endproperty
	a_hib: assert property (p_hib) else $error("precise monitor on in hibernate");
	// interrupt presentation
	property p_hv; vdda_over_i && monitor_enable_o && !sleep_i |-> ##[1:4] supply_irq_o; endproperty
	a_hv: assert property (p_hv) else $error("overvoltage without irq");
	property p_slp; $past(sleep_i, 2) |-> !supply_irq_o; endproperty
	a_slp: assert property (p_slp) else $error("irq presented while asleep");
endmodule

bind srs_reset_supervisor srs_reset_supervisor_props #(.RELEASE_CYC(RELEASE_CYC)) chk_u (.*);

// *** verification/tb_srs_reset_supervisor.sv ***
`timescale 1ns/100ps
module tb_srs_reset_supervisor;
	import srs_pkg::*;
	logic clk_i, nrst_i, sleep_i, hibernate_i, wr_i, rd_i;
	logic power_on_trip_i, supply_ramping_i, precise_dig_trip_i, precise_ana_trip_i, external_reset_pin_n_i, vdda_over_i;
	logic sys_reset_n_o, power_on_enable_o, precise_dig_enable_o, precise_ana_enable_o;
	logic monitor_enable_o, external_reset_pullup_o, wake_req_o, supply_irq_o;
	logic [3:0] addr_i, vddd_level_i, vdda_level_i;
	logic [31:0] wdata_i, rdata_o;
	int bad_count = 0;
	int num_checks = 0;
	srs_reset_supervisor dut_u (.*);
	srs_supply_model pm (.*);
	// ****
	// bus and compare tasks
	// ****
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rdc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(negedge clk_i);
		chk(rdata_o & m, e);
		@(posedge clk_i);
	endtask
	// bounded wait for a reset level
	task automatic waitr(input logic v, input int n);
		@(negedge clk_i);
		for (int i = 0; i < n && sys_reset_n_o !== v; i++) @(negedge clk_i);
		chk({31'h0, sys_reset_n_o}, {31'h0, v});
		@(posedge clk_i);
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ****
	// clock, watchdog, tests
	// ****
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	initial begin
		#400000 bad_count++;
		summarize();
	end
	initial begin
		{nrst_i, sleep_i, hibernate_i, wr_i, rd_i} = 5'h0;
		addr_i = 4'h0;
		wdata_i = 32'h0;
		repeat (8) @(posedge clk_i);
		nrst_i <= 1'b1;
		waitr(1'b1, 100);
		rdc(REG_STATUS, 32'hff, 32'h0);
		rdc(REG_WDT_CTRL, 32'h1, 32'h0);
		wr(REG_BUZZ, 32'h20);
		wr(REG_SWRST, 32'h1);
		waitr(1'b0, 10);
		waitr(1'b1, 100);
		rdc(REG_BUZZ, 32'hffff, {16'h0, BUZZ_RST});
		rdc(REG_STATUS, 32'hff, 32'h1 << ST_SOFT);
		wr(REG_STATUS, 32'hff);
		rdc(REG_STATUS, 32'hff, 32'h0);
		// blocked software reset
		wr(REG_SWRST, 32'h2);
		wr(REG_SWRST, 32'h3);
		repeat (10) @(posedge clk_i);
		waitr(1'b1, 1);
		rdc(REG_STATUS, 32'hff, 32'h0);
		wr(REG_SWRST, 32'h0);
		// precise trip, pin awake and in hibernate
		pm.precise_lv_reset_pulse(6);
		waitr(1'b1, 100);
		pm.pin_low(8);
		waitr(1'b1, 100);
		hibernate_i <= 1'b1;
		pm.pin_low(8);
		hibernate_i <= 1'b0;
		waitr(1'b1, 100);
		rdc(REG_STATUS, 32'hff, (32'h1 << ST_PRECISE) | (32'h1 << ST_PIN));
		wr(REG_STATUS, 32'hff);
		// trip code boundary, sleep wake, reset mode
		wr(REG_LV_CFG, 32'h3);
		pm.lv(4'h4, 4'hf, 1'b0);
		repeat (8) @(posedge clk_i);
		rdc(REG_STATUS, 32'hff, 32'h0);
		pm.lv(4'h3, 4'hf, 1'b0);
		repeat (8) @(posedge clk_i);
		rdc(REG_STATUS, 32'hff, 32'h1 << ST_DLOW);
		sleep_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		chk({wake_req_o, supply_irq_o}, 32'h2);
		@(posedge clk_i);
		sleep_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		chk({wake_req_o, supply_irq_o}, 32'h1);
		@(posedge clk_i);
		wr(REG_STATUS, 32'hff);
		wr(REG_LV_CFG, 32'h103);
		waitr(1'b0, 10);
		pm.lv(4'hf, 4'hf, 1'b0);
		waitr(1'b1, 100);
		pm.lv(4'hf, 4'hf, 1'b1);
		repeat (8) @(posedge clk_i);
		rdc(REG_STATUS, 32'h1 << ST_AHIGH, 32'h1 << ST_AHIGH);
		pm.lv(4'hf, 4'hf, 1'b0);
		// watchdog kicked, then starved
		wr(REG_WDT_CTRL, 32'h40);
		wr(REG_WDT_CTRL, 32'h41);
		repeat (3) begin
			repeat (40) @(posedge clk_i);
			wr(REG_WDT_KICK, 32'h0);
		end
		waitr(1'b1, 1);
		waitr(1'b0, 200);
		waitr(1'b1, 100);
		wr(REG_WDT_CTRL, 32'h0);
		rdc(REG_WDT_CTRL, 32'h1, 32'h1);
		rdc(REG_STATUS, 32'h1 << ST_WDOG, 32'h1 << ST_WDOG);
		// power-on clears status and enable
		nrst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		nrst_i <= 1'b1;
		waitr(1'b1, 100);
		rdc(REG_STATUS, 32'hff, 32'h0);
		rdc(REG_WDT_CTRL, 32'h1, 32'h0);
		summarize();
	end
endmodule
